// [aad_defs.svh]
// Constants for the accumulator add and logic datapath
`ifndef AAD_DEFS_SVH
`define AAD_DEFS_SVH

`define AAD_DATA_W 8
`define AAD_ADDR_W 8
`define AAD_FLAG_W 5
`define AAD_FLAG_SIGN_FAULT 0
`define AAD_FLAG_ZERO 1
`define AAD_FLAG_NIBBLE_SPILL 2
`define AAD_FLAG_CARRY 3
`define AAD_FLAG_SIGNED_SPILL 4
`define AAD_FLAGS_RESET 5'h00
`define AAD_NIBBLE_MSB 3
`define AAD_READ_LATENCY 1

`endif

// [aad_pkg.sv]
// Types for the accumulator add and logic datapath
`include "aad_defs.svh"
package aad_pkg;

    typedef enum logic [1:0] {
        AAD_OP_MEMORY_SUM_WRITEBACK = 2'h0,
        AAD_OP_AND_MEMORY = 2'h1,
        AAD_OP_AND_IMMEDIATE = 2'h2,
        AAD_OP_MEMORY_MASK_WRITEBACK = 2'h3
    } aad_op_t;

    typedef enum logic [1:0] {
        AAD_ST_IDLE = 2'h0,
        AAD_ST_FETCH = 2'h1,
        AAD_ST_WRITE = 2'h3
    } aad_state_t;

    typedef struct packed {
        aad_state_t st;
        aad_op_t op;
        logic [`AAD_DATA_W-1:0] acc;
        logic [`AAD_DATA_W-1:0] imm;
        logic [`AAD_ADDR_W-1:0] addr;
        logic acc_we;
        logic [`AAD_DATA_W-1:0] acc_wdata;
        logic mem_we;
        logic [`AAD_DATA_W-1:0] mem_wdata;
        logic done;
        logic [`AAD_FLAG_W-1:0] flags;
    } aad_regs_t;

endpackage

// [aad_alu.sv]
// Combinational sum and mask unit with flag generation
`timescale 1ns/1ns
`include "aad_defs.svh"
module aad_alu (
    input wire aad_pkg::aad_op_t op_i,
    input wire logic [`AAD_DATA_W-1:0] acc_i,
    input wire logic [`AAD_DATA_W-1:0] operand_i,
    input wire logic [`AAD_FLAG_W-1:0] flags_i,
    output logic [`AAD_DATA_W-1:0] result_o,
    output logic [`AAD_FLAG_W-1:0] flags_o
);

    function automatic logic is_zero(input logic [`AAD_DATA_W-1:0] v);
        is_zero = (v == '0);
    endfunction

    logic [`AAD_DATA_W:0] sum;
    logic [`AAD_NIBBLE_MSB+1:0] low_sum;
    logic sign_fault;

    always_comb begin
        sum = {1'b0, acc_i} + {1'b0, operand_i};
        low_sum = {1'b0, acc_i[`AAD_NIBBLE_MSB:0]} + {1'b0, operand_i[`AAD_NIBBLE_MSB:0]};
        sign_fault = (acc_i[`AAD_DATA_W-1] == operand_i[`AAD_DATA_W-1])
            && (sum[`AAD_DATA_W-1] != acc_i[`AAD_DATA_W-1]);
        flags_o = flags_i;
        if (op_i == aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK) begin
            result_o = sum[`AAD_DATA_W-1:0];
            flags_o[`AAD_FLAG_SIGN_FAULT] = sign_fault; // RL1
            flags_o[`AAD_FLAG_ZERO] = is_zero(sum[`AAD_DATA_W-1:0]); // RL1
            flags_o[`AAD_FLAG_NIBBLE_SPILL] = low_sum[`AAD_NIBBLE_MSB+1]; // RL1
            flags_o[`AAD_FLAG_CARRY] = sum[`AAD_DATA_W]; // RL1
            flags_o[`AAD_FLAG_SIGNED_SPILL] = sign_fault ^ sum[`AAD_DATA_W-1]; // RL1
        end else begin
            result_o = acc_i & operand_i; // RL2 RL3 RL4
            flags_o[`AAD_FLAG_ZERO] = is_zero(acc_i & operand_i); // RL2 RL3 RL5
        end
    end

endmodule // aad_alu

// [aad_datapath.sv]
// Accumulator add and logic datapath slice with sequencing
`timescale 1ns/1ns
`include "aad_defs.svh"
// Overview of operation
// RL1: Memory sum writeback, five flags updated
// RL2: AND memory into accumulator, zero only
// RL3: AND immediate into accumulator, zero only
// RL4: Memory mask writeback goes to memory
// RL5: Mask writeback: zero only, accumulator kept
module aad_datapath (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire aad_pkg::aad_op_t req_op_i,
    input wire logic [`AAD_DATA_W-1:0] req_acc_i,
    input wire logic [`AAD_DATA_W-1:0] req_imm_i,
    input wire logic [`AAD_ADDR_W-1:0] req_addr_i,
    output logic req_ready_o,
    output logic mem_rd_o,
    output logic [`AAD_ADDR_W-1:0] mem_addr_o,
    input wire logic [`AAD_DATA_W-1:0] mem_rd_data_i,
    output logic mem_we_o,
    output logic [`AAD_DATA_W-1:0] mem_wdata_o,
    output logic acc_we_o,
    output logic [`AAD_DATA_W-1:0] acc_wdata_o,
    output logic done_o,
    output logic [`AAD_FLAG_W-1:0] flags_o
);

    aad_pkg::aad_regs_t s;
    aad_pkg::aad_regs_t next_s;
    logic [`AAD_DATA_W-1:0] alu_operand;
    logic [`AAD_DATA_W-1:0] alu_result;
    logic [`AAD_FLAG_W-1:0] alu_flags;

    assign alu_operand = (s.op == aad_pkg::AAD_OP_AND_IMMEDIATE) ? s.imm : mem_rd_data_i;

    aad_alu u_alu (
        .op_i(s.op),
        .acc_i(s.acc),
        .operand_i(alu_operand),
        .flags_i(s.flags),
        .result_o(alu_result),
        .flags_o(alu_flags)
    );

    always_comb begin
        next_s = s;
        next_s.acc_we = 1'b0;
        next_s.mem_we = 1'b0;
        next_s.done = 1'b0;
        case (s.st)
            aad_pkg::AAD_ST_IDLE: begin
                if (req_valid_i) begin
                    next_s.op = req_op_i;
                    next_s.acc = req_acc_i;
                    next_s.imm = req_imm_i;
                    next_s.addr = req_addr_i;
                    if (req_op_i == aad_pkg::AAD_OP_AND_IMMEDIATE) begin
                        next_s.st = aad_pkg::AAD_ST_WRITE; // RL3
                    end else begin
                        next_s.st = aad_pkg::AAD_ST_FETCH;
                    end
                end
            end
            aad_pkg::AAD_ST_FETCH: begin
                next_s.st = aad_pkg::AAD_ST_WRITE;
            end
            aad_pkg::AAD_ST_WRITE: begin
                next_s.st = aad_pkg::AAD_ST_IDLE;
                next_s.done = 1'b1;
                next_s.flags = alu_flags;
                case (s.op)
                    aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK,
                    aad_pkg::AAD_OP_MEMORY_MASK_WRITEBACK: begin // RL5
                        next_s.mem_we = 1'b1; // RL1 RL4
                        next_s.mem_wdata = alu_result; // RL1 RL4
                    end
                    default: begin
                        next_s.acc_we = 1'b1; // RL2 RL3
                        next_s.acc_wdata = alu_result; // RL2 RL3
                    end
                endcase
            end
            default: begin
                next_s.st = aad_pkg::AAD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s <= '{st: aad_pkg::AAD_ST_IDLE, op: aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK,
                   flags: `AAD_FLAGS_RESET, default: '0};
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign req_ready_o = (s.st == aad_pkg::AAD_ST_IDLE);
    assign mem_rd_o = (s.st == aad_pkg::AAD_ST_FETCH);
    assign mem_addr_o = s.addr;
    assign mem_we_o = s.mem_we;
    assign mem_wdata_o = s.mem_wdata;
    assign acc_we_o = s.acc_we;
    assign acc_wdata_o = s.acc_wdata;
    assign done_o = s.done;
    assign flags_o = s.flags;

    // Checks
    sequence seq_sum_exec;
        s.st == aad_pkg::AAD_ST_WRITE && s.op == aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK && ce_i;
    endsequence

    sequence seq_mem_req(aad_pkg::aad_op_t op);
        req_ready_o && req_valid_i && ce_i && req_op_i == op ##1 ce_i [*2];
    endsequence

    sequence seq_mask_exec;
        s.st == aad_pkg::AAD_ST_WRITE && s.op == aad_pkg::AAD_OP_MEMORY_MASK_WRITEBACK && ce_i;
    endsequence

    sequence seq_imm_take;
        req_ready_o && req_valid_i && ce_i && req_op_i == aad_pkg::AAD_OP_AND_IMMEDIATE;
    endsequence

    AST_SUM_WRITEBACK: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1
        seq_sum_exec |=> mem_we_o && !acc_we_o
            && mem_wdata_o == 8'($past(s.acc) + $past(mem_rd_data_i)))
        else $error("Sum writeback data wrong");

    AST_SUM_CARRY: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1
        seq_sum_exec |=> flags_o[`AAD_FLAG_CARRY]
            == (({1'b0, $past(s.acc)} + {1'b0, $past(mem_rd_data_i)}) > 9'h0ff)
            && flags_o[`AAD_FLAG_ZERO] == (mem_wdata_o == 8'h00))
        else $error("Sum carry or zero flag wrong");

    AST_AND_MEMORY: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL2
        seq_mem_req(aad_pkg::AAD_OP_AND_MEMORY) ##1 1'b1
            |-> acc_we_o && !mem_we_o && acc_wdata_o == ($past(s.acc) & $past(mem_rd_data_i))
            && flags_o[`AAD_FLAG_ZERO] == (acc_wdata_o == 8'h00))
        else $error("Memory AND result wrong");

    AST_AND_KEEPS_FLAGS: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL2 RL3 RL5
        s.st == aad_pkg::AAD_ST_WRITE && s.op != aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK && ce_i
            |=> {flags_o[4:2], flags_o[0]} == $past({s.flags[4:2], s.flags[0]}))
        else $error("AND disturbed a flag other than zero");

    AST_AND_IMMEDIATE: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL3
        req_ready_o && req_valid_i && ce_i && req_op_i == aad_pkg::AAD_OP_AND_IMMEDIATE
            ##1 ce_i |=> acc_we_o && !mem_rd_o && acc_wdata_o == ($past(req_acc_i, 2) & $past(req_imm_i, 2)))
        else $error("Immediate AND result wrong");

    AST_MASK_WRITEBACK: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL4 RL5
        seq_mem_req(aad_pkg::AAD_OP_MEMORY_MASK_WRITEBACK) ##1 1'b1
            |-> mem_we_o && !acc_we_o && mem_wdata_o == ($past(s.acc) & $past(mem_rd_data_i)))
        else $error("Mask writeback wrong");

    AST_FETCH_ONE_CYCLE: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1 RL2 RL4
        mem_rd_o && ce_i ##1 ce_i
            |-> !mem_rd_o && !req_ready_o ##1 done_o && req_ready_o)
        else $error("Memory read phase length wrong");

    AST_DONE_PULSE: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1 RL2 RL3 RL4
        done_o && ce_i |=> !done_o && !mem_we_o && !acc_we_o)
        else $error("Completion pulse too long");

    AST_SUM_LOW_FLAGS: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1
        seq_sum_exec |=> flags_o[`AAD_FLAG_NIBBLE_SPILL]
            == (({1'b0, $past(s.acc[`AAD_NIBBLE_MSB:0])}
                + {1'b0, $past(mem_rd_data_i[`AAD_NIBBLE_MSB:0])}) > 5'h0f))
        else $error("Sum nibble spill flag wrong");

    AST_SUM_SIGN_FLAGS: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1
        seq_sum_exec |=> flags_o[`AAD_FLAG_SIGN_FAULT]
            == ($past(s.acc[`AAD_DATA_W-1]) == $past(mem_rd_data_i[`AAD_DATA_W-1])
                && mem_wdata_o[`AAD_DATA_W-1] != $past(s.acc[`AAD_DATA_W-1]))
            && flags_o[`AAD_FLAG_SIGNED_SPILL] == (flags_o[`AAD_FLAG_SIGN_FAULT] ^ mem_wdata_o[`AAD_DATA_W-1]))
        else $error("Sum sign flags wrong");

    AST_MASK_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL5
        seq_mask_exec |=> flags_o[`AAD_FLAG_ZERO] == (mem_wdata_o == 8'h00)
            && acc_wdata_o == $past(acc_wdata_o) && !acc_we_o)
        else $error("Mask writeback zero flag or accumulator wrong");

    AST_IMM_NO_FETCH: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL3
        seq_imm_take |=> !mem_rd_o && !req_ready_o && !done_o)
        else $error("Immediate AND read memory");

    AST_ACC_OPS_NO_MEM_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL2 RL3
        s.st == aad_pkg::AAD_ST_WRITE && ce_i
            && (s.op == aad_pkg::AAD_OP_AND_MEMORY || s.op == aad_pkg::AAD_OP_AND_IMMEDIATE)
            |=> acc_we_o && done_o && !mem_we_o && $stable(mem_wdata_o))
        else $error("Accumulator AND wrote memory");

    AST_FETCH_ADDRESS: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1 RL2 RL4
        req_ready_o && req_valid_i && ce_i && req_op_i != aad_pkg::AAD_OP_AND_IMMEDIATE
            |=> mem_rd_o && mem_addr_o == $past(req_addr_i))
        else $error("Fetch address wrong");

    AST_ONE_STROBE: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1 RL2 RL3 RL4
        done_o == (mem_we_o || acc_we_o) && !(mem_we_o && acc_we_o))
        else $error("Completion and write strobes disagree");

    AST_DATA_HOLDS: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL4 RL5
        !$past(rst_i) |-> (mem_we_o || $stable(mem_wdata_o)) && (acc_we_o || $stable(acc_wdata_o)))
        else $error("Write data moved without a strobe");

    AST_WRITE_HELD: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL1 RL4
        s.st == aad_pkg::AAD_ST_WRITE && !ce_i |=> s.st == aad_pkg::AAD_ST_WRITE && !done_o)
        else $error("Write phase left while frozen");

    // Clock enable and reset
    AST_CE_FREEZE: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !ce_i |=> $stable(s))
        else $error("State moved while clock enable low");

    AST_RESET_IDLE: assert property (@(posedge core_clk_i)
        rst_i |=> req_ready_o && !mem_rd_o && !done_o && !mem_we_o && !acc_we_o
            && flags_o == `AAD_FLAGS_RESET)
        else $error("Reset left the block busy or flags set");

endmodule // aad_datapath

// [aad_mem_model.sv]
// Data memory model answering the datapath's fetch one cycle later
`timescale 1ns/1ns
`include "aad_defs.svh"
module aad_mem_model (
    input wire logic core_clk_i,
    input wire logic ce_i,
    input wire logic mem_rd_i,
    input wire logic [`AAD_ADDR_W-1:0] mem_addr_i,
    input wire logic mem_we_i,
    input wire logic [`AAD_DATA_W-1:0] mem_wdata_i,
    output logic [`AAD_DATA_W-1:0] mem_rd_data_o
);
    logic [`AAD_DATA_W-1:0] mem [0:(1<<`AAD_ADDR_W)-1];
    initial mem_rd_data_o = 8'h00;
    always @(posedge core_clk_i) begin
        if (ce_i && mem_we_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
        // Valid only after a fetch, held while frozen, toggling otherwise
        if (ce_i && mem_rd_i) begin
            mem_rd_data_o <= mem[mem_addr_i];
        end else if (ce_i) begin
            mem_rd_data_o <= ~mem_rd_data_o;
        end
    end
endmodule // aad_mem_model

// [tb.sv]
// Self-checking testbench for the accumulator add and logic datapath
`timescale 1ns/1ns
`include "aad_defs.svh"
module tb;
    logic core_clk_i, rst_i, ce_i, req_valid_i, req_ready_o, mem_rd_o, mem_we_o, acc_we_o, done_o;
    aad_pkg::aad_op_t req_op_i;
    logic [7:0] req_acc_i, req_imm_i, req_addr_i, mem_addr_o, mem_rd_data_i, mem_wdata_o, acc_wdata_o;
    logic [4:0] flags_o, exp_f;
    int mismatches = 0;
    int tests_run = 0;
    int lat;
    aad_datapath dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
        .req_op_i(req_op_i), .req_acc_i(req_acc_i), .req_imm_i(req_imm_i), .req_addr_i(req_addr_i),
        .req_ready_o(req_ready_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rd_data_i(mem_rd_data_i),
        .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .acc_we_o(acc_we_o), .acc_wdata_o(acc_wdata_o),
        .done_o(done_o), .flags_o(flags_o));
    aad_mem_model mem_m (.core_clk_i(core_clk_i), .ce_i(ce_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
        .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o), .mem_rd_data_o(mem_rd_data_i));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // Issues one request and returns in its done cycle
    task automatic do_op(input aad_pkg::aad_op_t op, input logic [7:0] acc, imm, adr, m);
        mem_m.mem[adr] = m;
        req_op_i = op;
        req_acc_i = acc;
        req_imm_i = imm;
        req_addr_i = adr;
        req_valid_i = 1'b1;
        check(8'(req_ready_o), 8'h01, "ready");
        @(posedge core_clk_i);
        #1 req_valid_i = 1'b0;
        lat = 1;
        while (done_o !== 1'b1) begin
            if (lat > 8) begin
                mismatches++;
                summarize();
            end
            @(posedge core_clk_i);
            #1 lat++;
        end
    endtask
    function automatic logic [4:0] addf(input logic [7:0] a, m);
        logic [8:0] s;
        logic [4:0] f;
        s = a + m;
        f[`AAD_FLAG_SIGN_FAULT] = (a[7] == m[7]) && (s[7] != a[7]);
        f[`AAD_FLAG_ZERO] = s[7:0] == 8'h00;
        f[`AAD_FLAG_NIBBLE_SPILL] = (5'(a[3:0]) + 5'(m[3:0])) > 5'h0f;
        f[`AAD_FLAG_CARRY] = s[8];
        f[`AAD_FLAG_SIGNED_SPILL] = f[`AAD_FLAG_SIGN_FAULT] ^ s[7];
        return f;
    endfunction
    task automatic sc_add();
        logic [7:0] a [4] = '{8'h7f, 8'hff, 8'h0f, 8'h80};
        logic [7:0] m [4] = '{8'h01, 8'h01, 8'h01, 8'h80};
        for (int i = 0; i < 4; i++) begin
            do_op(aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK, a[i], 8'h00, 8'(i + 3), m[i]);
            exp_f = addf(a[i], m[i]);
            check(8'(lat), 8'h03, "add latency");
            check(8'(mem_we_o), 8'h01, "add mem write");
            check(mem_wdata_o, a[i] + m[i], "add sum");
            check(mem_addr_o, 8'(i + 3), "add address");
            check(8'(flags_o), 8'(exp_f), "add flags");
            check(8'(acc_we_o), 8'h00, "add acc write");
        end
        @(posedge core_clk_i);
        #1 check(mem_m.mem[8'h06], 8'h00, "add stored");
    endtask
    task automatic sc_and_mem();
        do_op(aad_pkg::AAD_OP_AND_MEMORY, 8'hf0, 8'h00, 8'h20, 8'h3c);
        exp_f[`AAD_FLAG_ZERO] = 1'b0;
        check(8'(acc_we_o), 8'h01, "and mem acc write");
        check(acc_wdata_o, 8'h30, "and mem result");
        check(8'(mem_we_o), 8'h00, "and mem no mem write");
        check(8'(flags_o), 8'(exp_f), "and mem flags");
    endtask
    task automatic sc_and_imm();
        do_op(aad_pkg::AAD_OP_AND_IMMEDIATE, 8'h0f, 8'hf0, 8'h21, 8'hff);
        exp_f[`AAD_FLAG_ZERO] = 1'b1;
        check(8'(lat), 8'h02, "and imm latency");
        check(8'(acc_we_o), 8'h01, "and imm acc write");
        check(acc_wdata_o, 8'h00, "and imm result");
        check(8'(flags_o), 8'(exp_f), "and imm flags");
    endtask
    task automatic sc_mask_wb();
        do_op(aad_pkg::AAD_OP_MEMORY_MASK_WRITEBACK, 8'haa, 8'h00, 8'h22, 8'h0f);
        exp_f[`AAD_FLAG_ZERO] = 1'b0;
        check(8'(mem_we_o), 8'h01, "mask mem write");
        check(mem_wdata_o, 8'h0a, "mask result");
        check(8'(acc_we_o), 8'h00, "mask acc untouched");
        check(acc_wdata_o, 8'h00, "mask acc data held");
        check(8'(flags_o), 8'(exp_f), "mask flags");
        @(posedge core_clk_i);
        #1 check(mem_m.mem[8'h22], 8'h0a, "mask stored");
    endtask
    // Reset in mid fetch, then a request at the first edge after release
    task automatic sc_reset_mid();
        req_op_i = aad_pkg::AAD_OP_AND_MEMORY;
        req_valid_i = 1'b1;
        @(posedge core_clk_i);
        #1 req_valid_i = 1'b0;
        rst_i = 1'b1;
        @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        check(8'(req_ready_o), 8'h01, "ready after reset");
        check(8'(flags_o), 8'(`AAD_FLAGS_RESET), "flags after reset");
        do_op(aad_pkg::AAD_OP_AND_IMMEDIATE, 8'h3c, 8'h0f, 8'h00, 8'h00);
        check(8'(lat), 8'h02, "imm latency after reset");
        check(acc_wdata_o, 8'h0c, "imm result after reset");
        check(8'({mem_we_o, flags_o}), 8'h00, "imm no memory write, flags clear");
    endtask
    // Clock enable dropped in the fetch and in the write phase of an add
    task automatic sc_stall();
        mem_m.mem[8'h30] = 8'h11;
        req_op_i = aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK;
        req_acc_i = 8'h22;
        req_addr_i = 8'h30;
        req_valid_i = 1'b1;
        @(posedge core_clk_i);
        #1 req_valid_i = 1'b0;
        ce_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 check(8'(mem_rd_o), 8'h01, "fetch held while frozen");
        ce_i = 1'b1;
        @(posedge core_clk_i);
        #1 ce_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1 check(8'({done_o, mem_we_o}), 8'h00, "no write while frozen");
        ce_i = 1'b1;
        @(posedge core_clk_i);
        #1 check(8'({done_o, mem_we_o}), 8'h03, "write after freeze");
        check(mem_wdata_o, 8'h33, "sum after freeze");
        check(8'(flags_o), 8'(addf(8'h22, 8'h11)), "flags after freeze");
        @(posedge core_clk_i);
        #1 check(mem_m.mem[8'h30], 8'h33, "sum stored after freeze");
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        req_valid_i = 1'b0;
        req_op_i = aad_pkg::AAD_OP_MEMORY_SUM_WRITEBACK;
        req_acc_i = 8'h00;
        req_imm_i = 8'h00;
        req_addr_i = 8'h00;
        repeat (5) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        check(8'(flags_o), 8'(`AAD_FLAGS_RESET), "reset flags");
        sc_add();
        sc_and_mem();
        sc_and_imm();
        sc_mask_wb();
        sc_reset_mid();
        sc_stall();
        summarize();
    end
endmodule // tb
